/* File: rtl/lpc_ctrl.sv */
// Register file, two-wire slave, proximity sequencer and interrupt pin.
// Assumes converter inputs are on clk; bus pins are asynchronous and resolved outside.
`timescale 1ns/1ns
`default_nettype none
`include "lpc_params.svh"

module lpc_ctrl #(
  parameter logic [23:0] NEAR_CONV_CYCLES = 24'(`LPC_NEAR_CONV_US * `LPC_CLK_MHZ),
  parameter logic [23:0] IDLE_TICK_CYCLES = 24'(`LPC_IDLE_TICK_US * `LPC_CLK_MHZ),
  parameter logic [7:0]  PART_ID_VALUE    = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Two-wire bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Interrupt pin, open drain, active low
  input  wire logic        int_n_in,
  output logic             int_n_out,
  output logic             int_n_oe,
  // Light converter
  output logic             light_sense_on,
  output logic             light_range_high,
  output logic             light_spectrum_ir,
  input  wire logic        light_conv_done,
  input  wire logic [11:0] light_visible_data,
  input  wire logic [11:0] light_ir_data,
  // Proximity converter and emitter
  output logic             emitter_pulse_on,
  output logic             emitter_drive_high,
  input  wire logic [7:0]  near_adc_data
);

  lpc_pkg::lpc_config_type    cfg;
  lpc_pkg::lpc_config_type    next_cfg;
  lpc_pkg::lpc_intctl_type    intctl;
  lpc_pkg::lpc_intctl_type    next_intctl;
  lpc_pkg::lpc_bus_state_type bus_state;
  lpc_pkg::lpc_bus_state_type next_bus_state;
  lpc_pkg::lpc_near_state_type near_state;
  lpc_pkg::lpc_near_state_type next_near_state;
  logic [7:0]  near_lt, near_ht, next_near_lt, next_near_ht;
  logic [7:0]  th1, th2, th3, next_th1, next_th2, next_th3;
  logic [7:0]  near_result, next_near_result;
  logic [11:0] light_result, next_light_result;
  logic [11:0] light_sample;
  logic        scl_meta, scl_sync, scl_prev;
  logic        sda_meta, sda_sync, sda_prev;
  logic        scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0]  shift, next_shift;
  logic [3:0]  bitcnt, next_bitcnt;
  logic [3:0]  ptr, next_ptr, ptr_inc;
  logic        rw, next_rw, mack, next_mack, next_sda_oe;
  logic [7:0]  rdata;
  logic        wr_commit;
  logic [23:0] timer, next_timer;
  logic [10:0] ticks, next_ticks, idle_ticks;
  logic        near_done, next_emit;
  logic        near_flag, light_flag;
  logic        near_host_clr, light_host_clr, light_hit, next_int_oe;

  // Pins pass two flops before any logic looks at them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_meta <= 1'h1;
      scl_sync <= 1'h1;
      scl_prev <= 1'h1;
      sda_meta <= 1'h1;
      sda_sync <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // Bus events from the settled pin levels
  assign scl_rise   = scl_sync && !scl_prev;
  assign scl_fall   = !scl_sync && scl_prev;
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign ptr_inc    = (ptr == `LPC_REG_LIGHT_DT2) ? `LPC_REG_PART_ID : ptr + 4'h1;
  // Writes land only after the data byte is acknowledged
  assign wr_commit  = scl_fall && !start_seen && !stop_seen && (bus_state == lpc_pkg::bus_wr_ack);

  // Read data mux; unmapped offsets read zero
  always_comb begin
    case (ptr)
      `LPC_REG_PART_ID:   rdata = PART_ID_VALUE;
      `LPC_REG_CONFIG:    rdata = cfg;
      `LPC_REG_INT:       rdata = {near_flag, intctl.near_persist_count, 1'h0,
                                   light_flag, intctl.light_persist_count, intctl.combine_and};
      `LPC_REG_NEAR_LT:   rdata = near_lt;
      `LPC_REG_NEAR_HT:   rdata = near_ht;
      `LPC_REG_LIGHT_TH1: rdata = th1;
      `LPC_REG_LIGHT_TH2: rdata = th2;
      `LPC_REG_LIGHT_TH3: rdata = th3;
      `LPC_REG_NEAR_DATA: rdata = near_result;
      `LPC_REG_LIGHT_DT1: rdata = light_result[7:0];
      `LPC_REG_LIGHT_DT2: rdata = {4'h0, light_result[11:8]};
      default:            rdata = 8'h00;
    endcase
  end

  // Slave byte engine; SDA changes only while SCL is low
  always_comb begin
    next_bus_state = bus_state;
    next_shift     = shift;
    next_bitcnt    = bitcnt;
    next_ptr       = ptr;
    next_rw        = rw;
    next_mack      = mack;
    next_sda_oe    = sda_oe;
    if (start_seen) begin
      next_bus_state = lpc_pkg::bus_dev;
      next_bitcnt    = 4'h0;
      next_sda_oe    = 1'h0;
    end else if (stop_seen) begin
      next_bus_state = lpc_pkg::bus_idle;
      next_sda_oe    = 1'h0;
    end else if (scl_rise) begin
      case (bus_state)
        lpc_pkg::bus_dev, lpc_pkg::bus_reg, lpc_pkg::bus_wr: begin
          next_shift  = {shift[6:0], sda_sync};
          next_bitcnt = bitcnt + 4'h1;
        end
        lpc_pkg::bus_rd_ack: next_mack = !sda_sync;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (bus_state)
        lpc_pkg::bus_dev: if (bitcnt == 4'h8) begin
          if (shift[7:1] == `LPC_DEV_ADDR) begin
            next_bus_state = lpc_pkg::bus_dev_ack;
            next_rw        = shift[0];
            next_sda_oe    = 1'h1;
          end else begin
            next_bus_state = lpc_pkg::bus_idle;
          end
        end
        lpc_pkg::bus_reg: if (bitcnt == 4'h8) begin
          next_ptr       = shift[3:0];
          next_bus_state = lpc_pkg::bus_reg_ack;
          next_sda_oe    = 1'h1;
        end
        lpc_pkg::bus_wr: if (bitcnt == 4'h8) begin
          next_bus_state = lpc_pkg::bus_wr_ack;
          next_sda_oe    = 1'h1;
        end
        lpc_pkg::bus_dev_ack: begin
          next_bitcnt = 4'h0;
          if (rw) begin
            next_shift     = rdata;
            next_sda_oe    = !rdata[7];
            next_bus_state = lpc_pkg::bus_rd;
          end else begin
            next_sda_oe    = 1'h0;
            next_bus_state = lpc_pkg::bus_reg;
          end
        end
        lpc_pkg::bus_reg_ack, lpc_pkg::bus_wr_ack: begin
          next_sda_oe    = 1'h0;
          next_bitcnt    = 4'h0;
          next_bus_state = lpc_pkg::bus_wr;
          if (bus_state == lpc_pkg::bus_wr_ack)
            next_ptr = ptr_inc;
        end
        lpc_pkg::bus_rd: begin
          if (bitcnt == 4'h7) begin
            next_sda_oe    = 1'h0;
            next_ptr       = ptr_inc;
            next_bus_state = lpc_pkg::bus_rd_ack;
          end else begin
            next_bitcnt = bitcnt + 4'h1;
            next_shift  = {shift[6:0], 1'h0};
            next_sda_oe = !shift[6];
          end
        end
        lpc_pkg::bus_rd_ack: begin
          next_bitcnt = 4'h0;
          if (mack) begin
            next_shift     = rdata;
            next_sda_oe    = !rdata[7];
            next_bus_state = lpc_pkg::bus_rd;
          end else begin
            next_bus_state = lpc_pkg::bus_idle;
          end
        end
        default: next_bus_state = lpc_pkg::bus_idle;
      endcase
    end
  end

  // Register writes; read-only offsets ignore data
  always_comb begin
    next_cfg       = cfg;
    next_intctl    = intctl;
    next_near_lt   = near_lt;
    next_near_ht   = near_ht;
    next_th1       = th1;
    next_th2       = th2;
    next_th3       = th3;
    near_host_clr  = 1'h0;
    light_host_clr = 1'h0;
    if (wr_commit) begin
      case (ptr)
        `LPC_REG_CONFIG: next_cfg = shift;
        `LPC_REG_INT: begin
          next_intctl    = {shift[6:5], shift[2:0]};
          near_host_clr  = !shift[`LPC_INT_NEAR_FLAG];
          light_host_clr = !shift[`LPC_INT_LIGHT_FLAG];
        end
        `LPC_REG_NEAR_LT:   next_near_lt = shift;
        `LPC_REG_NEAR_HT:   next_near_ht = shift;
        `LPC_REG_LIGHT_TH1: next_th1 = shift;
        `LPC_REG_LIGHT_TH2: next_th2 = shift;
        `LPC_REG_LIGHT_TH3: next_th3 = shift;
        default: ;
      endcase
    end
  end

  // Light capture and window test on the incoming sample
  assign light_sample = cfg.light_spectrum_select ? light_ir_data : light_visible_data;
  assign light_hit    = (light_sample <= {th2[3:0], th1}) || (light_sample >= {th3, th2[7:4]});
  always_comb begin
    next_light_result = light_result;
    if (light_conv_done && cfg.light_sense_enable_bit)
      next_light_result = light_sample;
  end

  // Idle interval per code
  always_comb begin
    case (cfg.near_idle_interval)
      3'h0:    idle_ticks = `LPC_IDLE_TICKS_0;
      3'h1:    idle_ticks = `LPC_IDLE_TICKS_1;
      3'h2:    idle_ticks = `LPC_IDLE_TICKS_2;
      3'h3:    idle_ticks = `LPC_IDLE_TICKS_3;
      3'h4:    idle_ticks = `LPC_IDLE_TICKS_4;
      3'h5:    idle_ticks = `LPC_IDLE_TICKS_5;
      3'h6:    idle_ticks = `LPC_IDLE_TICKS_6;
      default: idle_ticks = `LPC_IDLE_TICKS_7;
    endcase
  end

  // Proximity sequencer; clearing enable aborts without a result
  assign near_done = cfg.near_enable && (near_state == lpc_pkg::px_convert)
                     && (timer == NEAR_CONV_CYCLES - 24'h1);
  always_comb begin
    next_near_state  = near_state;
    next_timer       = timer + 24'h1;
    next_ticks       = ticks;
    next_near_result = near_result;
    if (!cfg.near_enable) begin
      next_near_state = lpc_pkg::px_off;
      next_timer      = 24'h0;
    end else begin
      case (near_state)
        lpc_pkg::px_off: begin
          next_near_state = lpc_pkg::px_convert;
          next_timer      = 24'h0;
        end
        lpc_pkg::px_convert: if (near_done) begin
          next_near_result = near_adc_data;
          next_timer       = 24'h0;
          next_ticks       = idle_ticks;
          next_near_state  = (idle_ticks == 11'h000) ? lpc_pkg::px_convert : lpc_pkg::px_idle;
        end
        lpc_pkg::px_idle: if (timer == IDLE_TICK_CYCLES - 24'h1) begin
          next_timer = 24'h0;
          next_ticks = ticks - 11'h001;
          if (ticks == 11'h001)
            next_near_state = lpc_pkg::px_convert;
        end
        default: next_near_state = lpc_pkg::px_off;
      endcase
    end
    next_emit = (next_near_state == lpc_pkg::px_convert);
  end

  // Pin condition from the two flags
  assign next_int_oe = intctl.combine_and ? (near_flag && light_flag) : (near_flag || light_flag);

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state    <= lpc_pkg::bus_idle;
      shift        <= 8'h00;
      bitcnt       <= 4'h0;
      ptr          <= 4'h0;
      rw           <= 1'h0;
      mack         <= 1'h0;
      sda_oe       <= 1'h0;
      sda_out      <= 1'h0;
      cfg          <= `LPC_RST_CONFIG;
      intctl       <= `LPC_RST_INTCTL;
      near_lt      <= `LPC_RST_NEAR_LT;
      near_ht      <= `LPC_RST_NEAR_HT;
      th1          <= `LPC_RST_LIGHT_TH1;
      th2          <= `LPC_RST_LIGHT_TH2;
      th3          <= `LPC_RST_LIGHT_TH3;
      light_result <= 12'h000;
      near_result  <= 8'h00;
      near_state   <= lpc_pkg::px_off;
      timer        <= 24'h0;
      ticks        <= 11'h000;
      emitter_pulse_on <= 1'h0;
      int_n_oe     <= 1'h0;
      int_n_out    <= 1'h0;
    end else begin
      bus_state    <= next_bus_state;
      shift        <= next_shift;
      bitcnt       <= next_bitcnt;
      ptr          <= next_ptr;
      rw           <= next_rw;
      mack         <= next_mack;
      sda_oe       <= next_sda_oe;
      sda_out      <= 1'h0;
      cfg          <= next_cfg;
      intctl       <= next_intctl;
      near_lt      <= next_near_lt;
      near_ht      <= next_near_ht;
      th1          <= next_th1;
      th2          <= next_th2;
      th3          <= next_th3;
      light_result <= next_light_result;
      near_result  <= next_near_result;
      near_state   <= next_near_state;
      timer        <= next_timer;
      ticks        <= next_ticks;
      emitter_pulse_on <= next_emit;
      int_n_oe     <= next_int_oe;
      int_n_out    <= 1'h0;
    end
  end

  // Converter controls come straight from the configuration flops
  assign light_sense_on     = cfg.light_sense_enable_bit;
  assign light_range_high   = cfg.light_full_scale_select;
  assign light_spectrum_ir  = cfg.light_spectrum_select;
  assign emitter_drive_high = cfg.emitter_drive_strength;

  // Light channel: flag stays until the host clears it
  lpc_persist u_light_persist (
    .clk          (clk),
    .rst          (rst),
    .enable       (cfg.light_sense_enable_bit),
    .strobe       (light_conv_done),
    .set_cond     (light_hit),
    .clr_cond     (1'h0),
    .persist_code (intctl.light_persist_count),
    .host_clear   (light_host_clr),
    .flag         (light_flag)
  );

  // Proximity channel: high run sets, low run clears
  lpc_persist u_near_persist (
    .clk          (clk),
    .rst          (rst),
    .enable       (cfg.near_enable),
    .strobe       (near_done),
    .set_cond     (near_adc_data >= near_ht),
    .clr_cond     (near_adc_data <= near_lt),
    .persist_code (intctl.near_persist_count),
    .host_clear   (near_host_clr),
    .flag         (near_flag)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_spectrum_capture: assert property (
    light_conv_done && cfg.light_sense_enable_bit |=>
      light_result == ($past(cfg.light_spectrum_select) ? $past(light_ir_data) : $past(light_visible_data)))
    else $error("light result from wrong spectrum");
  chk_range_write: assert property (
    wr_commit && ptr == `LPC_REG_CONFIG |=> light_range_high == $past(shift[1]))
    else $error("range output not updated");
  chk_light_gate: assert property (
    !light_sense_on && light_conv_done |=> $stable(light_result))
    else $error("light result moved while disabled");
  chk_drive_write: assert property (
    wr_commit && ptr == `LPC_REG_CONFIG |=> emitter_drive_high == $past(shift[3]))
    else $error("drive output not updated");
  chk_conv_bound: assert property (
    near_state == lpc_pkg::px_convert |-> timer < NEAR_CONV_CYCLES)
    else $error("conversion overran");
  chk_idle_load: assert property (
    near_done |=> ticks == $past(idle_ticks))
    else $error("idle length wrong");
  chk_near_off: assert property (
    !cfg.near_enable |=> !emitter_pulse_on ##1 !emitter_pulse_on || cfg.near_enable)
    else $error("emitter active while disabled");
  chk_int_combine: assert property (
    ##1 int_n_oe == ($past(intctl.combine_and) ? ($past(near_flag) && $past(light_flag))
                                              : ($past(near_flag) || $past(light_flag))))
    else $error("interrupt pin combination wrong");

endmodule : lpc_ctrl
`default_nettype wire

/* File: rtl/lpc_params.svh */
// Constants of the light and proximity control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

// Clock and timing figures
`define LPC_CLK_MHZ          25
`define LPC_NEAR_CONV_US     540
`define LPC_IDLE_TICK_US     500

// Idle length per code, in 0.5 ms ticks (800,400,200,100,75,50,12.5,0 ms)
`define LPC_IDLE_TICKS_0     11'h640
`define LPC_IDLE_TICKS_1     11'h320
`define LPC_IDLE_TICKS_2     11'h190
`define LPC_IDLE_TICKS_3     11'h0C8
`define LPC_IDLE_TICKS_4     11'h096
`define LPC_IDLE_TICKS_5     11'h064
`define LPC_IDLE_TICKS_6     11'h019
`define LPC_IDLE_TICKS_7     11'h000

// Bus device address (seven bits)
`define LPC_DEV_ADDR         7'h44

// Register offsets
`define LPC_REG_PART_ID      4'h0
`define LPC_REG_CONFIG       4'h1
`define LPC_REG_INT          4'h2
`define LPC_REG_NEAR_LT      4'h3
`define LPC_REG_NEAR_HT      4'h4
`define LPC_REG_LIGHT_TH1    4'h5
`define LPC_REG_LIGHT_TH2    4'h6
`define LPC_REG_LIGHT_TH3    4'h7
`define LPC_REG_NEAR_DATA    4'h8
`define LPC_REG_LIGHT_DT1    4'h9
`define LPC_REG_LIGHT_DT2    4'hA

// Interrupt register field positions
`define LPC_INT_NEAR_FLAG    7
`define LPC_INT_LIGHT_FLAG   3

// Reset values
`define LPC_RST_CONFIG       8'h00
`define LPC_RST_INTCTL       5'h00
`define LPC_RST_NEAR_LT      8'h00
`define LPC_RST_NEAR_HT      8'hFF
`define LPC_RST_LIGHT_TH1    8'h00
`define LPC_RST_LIGHT_TH2    8'hF0
`define LPC_RST_LIGHT_TH3    8'hFF

// Persistence run lengths per code
`define LPC_PERSIST_N0       5'h01
`define LPC_PERSIST_N1       5'h04
`define LPC_PERSIST_N2       5'h08
`define LPC_PERSIST_N3       5'h10

`endif

/* File: rtl/lpc_pkg.sv */
// Types of the light and proximity control block.
// Assumes lpc_params.svh supplies the numeric constants.
package lpc_pkg;

  // Sensing configuration register layout, bit 7 first
  typedef struct packed {
    logic       near_enable;
    logic [2:0] near_idle_interval;
    logic       emitter_drive_strength;
    logic       light_sense_enable_bit;
    logic       light_full_scale_select;
    logic       light_spectrum_select;
  } lpc_config_type;

  // Writable fields of the interrupt register
  typedef struct packed {
    logic [1:0] near_persist_count;
    logic [1:0] light_persist_count;
    logic       combine_and;
  } lpc_intctl_type;

  // Two-wire slave byte phases
  typedef enum logic [3:0] {
    bus_idle, bus_dev, bus_dev_ack, bus_reg, bus_reg_ack,
    bus_wr, bus_wr_ack, bus_rd, bus_rd_ack
  } lpc_bus_state_type;

  // Proximity measurement sequencer
  typedef enum logic [1:0] {
    px_off, px_convert, px_idle
  } lpc_near_state_type;

endpackage : lpc_pkg

/* File: rtl/lpc_persist.sv */
// Persistence filter and sticky flag for one sensing channel.
// Assumes strobe is a one-cycle pulse per completed conversion on clk.
`timescale 1ns/1ns
`default_nettype none
`include "lpc_params.svh"

module lpc_persist (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Conversion events
  input  wire logic       enable,
  input  wire logic       strobe,
  input  wire logic       set_cond,
  input  wire logic       clr_cond,
  input  wire logic [1:0] persist_code,
  input  wire logic       host_clear,
  // Flag
  output logic            flag
);

  logic [4:0] run_need;
  logic [4:0] set_cnt;
  logic [4:0] clr_cnt;
  logic [4:0] next_set_cnt;
  logic [4:0] next_clr_cnt;
  logic       next_flag;
  logic       set_now;
  logic       clr_now;

  // Run length needed for the selected code
  always_comb begin
    case (persist_code)
      2'h0:    run_need = `LPC_PERSIST_N0;
      2'h1:    run_need = `LPC_PERSIST_N1;
      2'h2:    run_need = `LPC_PERSIST_N2;
      default: run_need = `LPC_PERSIST_N3;
    endcase
  end

  // Runs restart on any miss; counts saturate at the need
  always_comb begin
    next_set_cnt = set_cnt;
    next_clr_cnt = clr_cnt;
    set_now      = 1'h0;
    clr_now      = 1'h0;
    if (!enable) begin
      next_set_cnt = 5'h00;
      next_clr_cnt = 5'h00;
    end else if (strobe) begin
      next_set_cnt = set_cond ? ((set_cnt >= run_need) ? run_need : set_cnt + 5'h01) : 5'h00;
      next_clr_cnt = clr_cond ? ((clr_cnt >= run_need) ? run_need : clr_cnt + 5'h01) : 5'h00;
      set_now      = set_cond && (next_set_cnt >= run_need);
      clr_now      = clr_cond && (next_clr_cnt >= run_need);
    end
    // Set wins so a qualifying run in the clear cycle is kept
    if (set_now)
      next_flag = 1'h1;
    else if (host_clear || clr_now)
      next_flag = 1'h0;
    else
      next_flag = flag;
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_cnt <= 5'h00;
      clr_cnt <= 5'h00;
      flag    <= 1'h0;
    end else begin
      set_cnt <= next_set_cnt;
      clr_cnt <= next_clr_cnt;
      flag    <= next_flag;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_persist_run: assert property (
    $rose(flag) |-> $past(strobe) && $past(set_cond) && (set_cnt >= run_need))
    else $error("flag rose without a full run");
  chk_run_restart: assert property (
    enable && strobe && !set_cond |=> set_cnt == 5'h00)
    else $error("run not restarted on a miss");
  chk_disabled_idle: assert property (
    !enable |=> (set_cnt == 5'h00) && (flag == ($past(flag) && !$past(host_clear))))
    else $error("filter moved while disabled");
  chk_host_clear: assert property (
    host_clear && !(enable && strobe && set_cond) |=> !flag)
    else $error("host clear ignored");

endmodule : lpc_persist
`default_nettype wire

/* File: tb/lpc_host.sv */
// Host side two-wire bus master for the light and proximity block.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
`include "lpc_params.svh"

module lpc_host (
  // Clock
  input  wire logic clk,
  // Bus wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  logic nack_seen; // Sticky: device missed an acknowledge

  // Lines released at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nack_seen = 1'b0;
  end

  // Four clocks a half bit: 320 ns bus period
  task automatic half;
    repeat (4) @(negedge clk);
  endtask : half

  // Data moves one clock after SCL falls so it never looks like START or STOP
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      @(negedge clk);
      sda_low = !tx[i];
      repeat (3) @(negedge clk);
      scl = 1'b1;
      half();
      rx[i] = sda_line;
      scl = 1'b0;
    end
  endtask : byte9

  // Start or repeated start, stop
  task automatic start;
    @(negedge clk);
    sda_low = 1'b0;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    @(negedge clk);
    sda_low = 1'b1;
    repeat (3) @(negedge clk);
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop

  // Device address plus register pointer; offset zero is never used
  task automatic point(input logic [3:0] a);
    logic [8:0] rx;
    start();
    byte9({`LPC_DEV_ADDR, 2'b01}, rx);
    nack_seen |= rx[0];
    byte9({4'h0, a, 1'b1}, rx);
    nack_seen |= rx[0];
  endtask : point

  // Byte write; callers keep bit 4 of the interrupt register zero
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [8:0] rx;
    point(a);
    byte9({d, 1'b1}, rx);
    nack_seen |= rx[0];
    stop();
  endtask : wr

  // Byte read ended by a not-acknowledge
  task automatic rd(input logic [3:0] a, output logic [11:0] d);
    logic [8:0] rx;
    point(a);
    start();
    byte9({`LPC_DEV_ADDR, 2'b11}, rx);
    nack_seen |= rx[0];
    byte9(9'h1FF, rx);
    d = {4'h0, rx[8:1]};
    stop();
  endtask : rd
endmodule : lpc_host
`default_nettype wire

/* File: tb/tb_lpc_ctrl.sv */
// Self-checking bench for the light and proximity control block.
// Assumes shortened proximity timing: 20 clock conversions, 4 clock idle ticks.
`timescale 1ns/1ns
`default_nettype none

module tb_lpc_ctrl;
  logic        clk, rst, scl, sda_low, sda_out, sda_oe, int_n_out, int_n_oe, done, pulse_on;
  logic [11:0] ir, v;
  int          bad_count, checked, n, m;
  wire         sda_w = !(sda_low || (sda_oe && !sda_out)); // Pull-up wins when released

  lpc_host lpc_host_inst (.clk(clk), .sda_line(sda_w), .scl(scl), .sda_low(sda_low));
  lpc_ctrl #(.NEAR_CONV_CYCLES(24'h000014), .IDLE_TICK_CYCLES(24'h000004)) lpc_ctrl_inst (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .int_n_in(!int_n_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .light_sense_on(),
    .light_range_high(), .light_spectrum_ir(), .light_conv_done(done), .light_visible_data(12'h800),
    .light_ir_data(ir), .emitter_pulse_on(pulse_on), .emitter_drive_high(), .near_adc_data(8'hC3));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Conversions: IR data, visible data sits inside the window
  task automatic conv(input logic [11:0] d, input int k);
    repeat (k) begin
      ir = d;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      @(negedge clk);
    end
  endtask : conv

  // Main sequence
  initial begin
    rst = 1'b1;
    done = 1'b0;
    ir = 12'h000;
    bad_count = 0;
    checked = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    lpc_host_inst.rd(4'h1, v); check("config", v, 12'h000);
    lpc_host_inst.rd(4'h6, v); check("shared", v, 12'h0F0);
    lpc_host_inst.rd(4'h7, v); check("high", v, 12'h0FF);
    $display("test done: reset values");
    lpc_host_inst.wr(4'h1, 8'h07);
    lpc_host_inst.wr(4'h2, 8'h02);
    conv(12'hFFF, 3);
    conv(12'h800, 1);
    conv(12'hFFF, 3);
    check("pin early", 12'(int_n_oe), 12'h000);
    conv(12'hFFF, 1);
    check("pin set", 12'(int_n_oe), 12'h001);
    lpc_host_inst.rd(4'h9, v); check("result lo", v, 12'h0FF);
    lpc_host_inst.rd(4'hA, v); check("result hi", v, 12'h00F);
    lpc_host_inst.rd(4'h2, v); check("int reg", v, 12'h00A);
    lpc_host_inst.wr(4'h2, 8'h03);
    check("pin cleared", 12'(int_n_oe), 12'h000);
    conv(12'hFFF, 4);
    check("pin and", 12'(int_n_oe), 12'h000);
    lpc_host_inst.wr(4'h2, 8'h0A);
    check("pin or", 12'(int_n_oe), 12'h001);
    $display("test done: light interrupt");
    lpc_host_inst.wr(4'h1, 8'hE8);
    n = 0;
    m = 0;
    // First window is already running when the write returns, so skip it
    for (int i = 0; i < 200 && !pulse_on; i++) @(negedge clk);
    for (int i = 0; i < 200 && pulse_on; i++) @(negedge clk);
    while (!pulse_on && m < 300) begin m++; @(negedge clk); end
    while (pulse_on && n < 300) begin n++; @(negedge clk); end
    check("conv len", 12'(n), 12'h014);
    check("idle len", 12'(m), 12'h064);
    lpc_host_inst.wr(4'h1, 8'h00);
    repeat (150) @(negedge clk);
    check("emitter off", 12'(pulse_on), 12'h000);
    lpc_host_inst.rd(4'h8, v); check("near result", v, 12'h0C3);
    check("acks", 12'(lpc_host_inst.nack_seen), 12'h000);
    $display("test done: proximity timing");
    report_and_stop();
  end
endmodule : tb_lpc_ctrl
`default_nettype wire
